// ===== design/rlc_chan.sv
// Gain engine for one record channel, stepping once per audio sample.
// Assumes the level and the sample strobe come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module rlc_chan (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        en,
   input  wire logic        tick,
   input  wire logic [7:0]  in_att,
   input  wire logic [5:0]  noise,
   input  wire logic [5:0]  tmin,
   input  wire logic [5:0]  tmax,
   input  wire logic [3:0]  gmax,
   input  wire logic [3:0]  amax,
   input  wire logic [14:0] atk_per,
   input  wire logic [14:0] rel_per,
   input  wire logic [20:0] hold_per,
   output logic      [7:0]  gain,
   output logic             holding
);
   import rlc_pkg::*;

   rlc_phase_e         state_ff, nxt_state;
   logic signed [7:0]  gain_ff, nxt_gain;
   logic [14:0]        rate_ff, nxt_rate;
   logic [20:0]        hold_ff, nxt_hold;
   logic signed [9:0]  out_att, in_s, noise_s, tmin_s, tmax_s;
   logic signed [8:0]  hi_lim, lo_lim, gain9;
   logic [14:0]        per, cnt1;

   // Level codes are 1.5 dB steps; levels run in 0.5 dB units, so times three
   function automatic logic signed [9:0] x3(input logic [5:0] c);
      return $signed({4'b0000, c} + {3'b000, c, 1'b0});
   endfunction

   // Output level is input level less the applied gain (gain in whole dB)
   always_comb begin
      in_s    = $signed({2'b00, in_att});
      out_att = in_s - $signed({gain_ff[7], gain_ff, 1'b0});
      noise_s = x3(noise);
      tmin_s  = x3(tmin);
      tmax_s  = x3(tmax);
      hi_lim  = $signed({3'b000, gmax, 2'b00} + {4'b0000, gmax, 1'b0});
      lo_lim  = 9'sd0 - $signed({3'b000, amax, 2'b00} + {4'b0000, amax, 1'b0});
      gain9   = $signed({gain_ff[7], gain_ff});
   end

   // Phase selection and stepping, evaluated once per sample
   always_comb begin
      nxt_state = state_ff;
      nxt_gain  = gain_ff;
      nxt_rate  = rate_ff;
      nxt_hold  = hold_ff;
      per       = atk_per;
      cnt1      = 15'd1;
      if (!en) begin
         nxt_state = RLC_OFF;
         nxt_gain  = 8'sd0;
         nxt_rate  = 15'd0;
         nxt_hold  = 21'd0;
      end else if (tick) begin
         if (in_s > noise_s) begin
            nxt_state = state_ff;
         end else if (out_att < tmax_s) begin
            nxt_state = RLC_ATTACK;
         end else if (out_att > tmin_s) begin
            nxt_state = (hold_ff < hold_per) ? RLC_HOLD : RLC_RELEASE;
         end else begin
            nxt_state = RLC_STEADY;
         end
         if (state_ff == RLC_OFF && nxt_state == RLC_OFF) begin
            nxt_state = RLC_STEADY;
         end
         // A change of phase restarts the rate count
         cnt1 = ((state_ff == nxt_state) ? rate_ff : 15'd0) + 15'd1;
         per  = (nxt_state == RLC_ATTACK) ? atk_per : rel_per;
         // A quiet input must neither count nor step, whatever phase it sits in
         case ((in_s > noise_s) ? RLC_OFF : nxt_state)
            RLC_ATTACK: begin
               nxt_rate = (cnt1 >= per) ? 15'd0 : cnt1;
               if (cnt1 >= per && gain9 > lo_lim) begin
                  nxt_gain = gain_ff - 8'sd1;
                  nxt_hold = 21'd0;
               end
            end
            RLC_HOLD: begin
               nxt_hold = hold_ff + 21'd1;
               nxt_rate = 15'd0;
            end
            RLC_RELEASE: begin
               nxt_rate = (cnt1 >= per) ? 15'd0 : cnt1;
               if (cnt1 >= per && gain9 < hi_lim) begin
                  nxt_gain = gain_ff + 8'sd1;
               end
            end
            RLC_STEADY: begin
               nxt_rate = 15'd0;
               if (hold_ff < hold_per) begin
                  nxt_hold = hold_ff + 21'd1;
               end
            end
            default: begin
               nxt_rate = rate_ff;
            end
         endcase
         // Limits lowered by software pull the gain back at the next sample strobe
         if ($signed({nxt_gain[7], nxt_gain}) > hi_lim) begin
            nxt_gain = hi_lim[7:0];
         end else if ($signed({nxt_gain[7], nxt_gain}) < lo_lim) begin
            nxt_gain = lo_lim[7:0];
         end
      end
   end

   // Channel state registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= RLC_OFF;
         gain_ff  <= 8'sd0;
         rate_ff  <= 15'd0;
         hold_ff  <= 21'd0;
      end else begin
         state_ff <= nxt_state;
         gain_ff  <= nxt_gain;
         rate_ff  <= nxt_rate;
         hold_ff  <= nxt_hold;
      end
   end

   assign gain    = gain_ff;
   assign holding = (state_ff == RLC_HOLD);

endmodule
`default_nettype wire

// ===== design/rlc_level_ctl.sv
// Record level control: APB register bank plus four per-channel gain engines
// and the hybrid analog/digital gain split for the two ADCs.
// Assumes level measurements and the sample strobe come from the same clock
// domain, and that the APB master follows the standard setup/access protocol.
`timescale 1ns/10ps
`default_nettype none
module rlc_level_ctl (
   input  wire logic        clk,
   input  wire logic        nrst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Record path
   input  wire logic        sample_tick,
   input  wire logic [31:0] level_att,
   output logic      [31:0] dig_gain,
   output logic      [5:0]  ana_gain
);
   import rlc_pkg::*;

   // Configuration storage and derived fields
   logic [8:0][7:0]  cfg_ff;
   logic [9:0]       word_idx;
   logic             cfg_hit;
   logic             gain_hit;
   logic             stat_hit;
   logic [3:0]       cfg_sel;
   logic [1:0]       gain_sel;
   logic [7:0]       rd_byte;
   logic             setup_ph;
   logic             write_now;

   logic [3:0]       chan_en;
   logic [3:0]       hyb_sel;
   logic [3:0]       rel_code;
   logic [3:0]       atk_code;
   logic [3:0]       hold_code;
   logic [5:0]       noise_lvl;
   logic [5:0]       tmin_lvl;
   logic [5:0]       tmax_lvl;
   logic [3:0]       gmax_code;
   logic [3:0]       amax_code;
   logic [2:0]       ana_min;
   logic [2:0]       ana_max;
   logic             clip_en;
   logic [1:0]       clip_step;

   logic [14:0]      atk_per;
   logic [14:0]      rel_per;
   logic [20:0]      hold_per;

   logic [3:0][7:0]  chan_gain;
   logic [3:0]       chan_hold;
   logic [3:0][7:0]  dig_gain_ff;
   logic [1:0][2:0]  ana_gain_ff;
   logic [31:0]      prdata_ff;
   logic             pready_ff;
   logic             pslverr_ff;

   // Address decode: each register index sits at byte address 4*index
   always_comb begin
      word_idx = paddr[11:2];
      cfg_hit  = (word_idx >= {2'b00, RLC_IDX_ENABLE_HYBRID}) &&
                 (word_idx <= {2'b00, RLC_IDX_CLIP_GUARD});
      gain_hit = (word_idx >= {2'b00, RLC_IDX_GAIN_FIRST}) &&
                 (word_idx <  {2'b00, RLC_IDX_STATUS});
      stat_hit = (word_idx == {2'b00, RLC_IDX_STATUS});
      cfg_sel  = 4'(word_idx - {2'b00, RLC_IDX_ENABLE_HYBRID});
      gain_sel = 2'(word_idx - {2'b00, RLC_IDX_GAIN_FIRST});
   end

   // Phase qualifiers of the bus transfer
   assign setup_ph  = psel && !penable;
   assign write_now = psel && penable && pready_ff && pwrite;

   // Read mux; gain and hold status reflect live engine state
   always_comb begin
      rd_byte = 8'h00;
      if (cfg_hit) begin
         rd_byte = cfg_ff[cfg_sel] & RLC_MASK[cfg_sel];
      end else if (gain_hit) begin
         rd_byte = chan_gain[gain_sel];
      end else if (stat_hit) begin
         rd_byte = {4'h0, chan_hold};
      end
   end

   // One wait-free access phase: ready rises in the cycle after setup
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup_ph;
      end
   end

   // Unmapped addresses answer with an error, no state changes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pslverr_ff <= 1'b0;
      end else if (setup_ph) begin
         pslverr_ff <= !(cfg_hit || gain_hit || stat_hit);
      end else begin
         pslverr_ff <= 1'b0;
      end
   end

   // Read data is captured in setup so it is stable for the whole access
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup_ph && !pwrite) begin
         prdata_ff <= {24'h00_0000, rd_byte};
      end else if (!psel) begin
         prdata_ff <= 32'h0000_0000;
      end
   end

   // Configuration registers; only lane 0 carries data, reserved bits stay 0
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < RLC_NCFG; i++) begin
            cfg_ff[i] <= RLC_RST[i];
         end
      end else if (write_now && cfg_hit && pstrb[0]) begin
         cfg_ff[cfg_sel] <= pwdata[7:0] & RLC_MASK[cfg_sel];
      end
   end

   // Field extraction from the configuration bank
   always_comb begin
      chan_en   = cfg_ff[0][RLC_EN_LSB +: 4];
      hyb_sel   = cfg_ff[0][RLC_HYB_LSB +: 4];
      atk_code  = cfg_ff[1][RLC_ATK_LSB +: 4];
      rel_code  = cfg_ff[1][RLC_REL_LSB +: 4];
      hold_code = cfg_ff[2][RLC_HOLD_LSB +: 4];
      noise_lvl = cfg_ff[3][RLC_LVL_LSB +: 6];
      tmin_lvl  = cfg_ff[4][RLC_LVL_LSB +: 6];
      tmax_lvl  = cfg_ff[5][RLC_LVL_LSB +: 6];
      amax_code = cfg_ff[6][RLC_ATTN_LSB +: 4];
      gmax_code = cfg_ff[6][RLC_GMAX_LSB +: 4];
      ana_min   = cfg_ff[7][RLC_AMIN_LSB +: 3];
      ana_max   = cfg_ff[7][RLC_AMAX_LSB +: 3];
      clip_en   = cfg_ff[8][RLC_CLIP_EN_BIT];
      clip_step = cfg_ff[8][RLC_CLIP_STEP_LSB +: 2];
   end

   // Rate decode into sample periods per dB.
   // The clip guard overrides the attack rate; it shares the fall path so
   // the two cannot fight over the same gain step.
   always_comb begin
      rel_per  = RLC_REL_TBL[rel_code];
      atk_per  = clip_en ? RLC_CLIP_TBL[clip_step]
                         : RLC_ATK_TBL[atk_code];
      hold_per = RLC_HOLD_BASE << hold_code;
   end

   // One gain engine per channel, all stepped by the shared sample strobe
   for (genvar c = 0; c < 4; c++) begin : g_chan
      rlc_chan u_chan (
         .clk      (clk),
         .nrst     (nrst),
         .en       (chan_en[c]),
         .tick     (sample_tick),
         .in_att   (level_att[8*c +: 8]),
         .noise    (noise_lvl),
         .tmin     (tmin_lvl),
         .tmax     (tmax_lvl),
         .gmax     (gmax_code),
         .amax     (amax_code),
         .atk_per  (atk_per),
         .rel_per  (rel_per),
         .hold_per (hold_per),
         .gain     (chan_gain[c]),
         .holding  (chan_hold[c])
      );
   end

   // Hybrid split per ADC: the left channel's gain picks the analog step,
   // the digital gain of both channels makes up the remainder.
   // Analog codes above 24 dB for the maximum are reserved and cut back.
   for (genvar a = 0; a < 2; a++) begin : g_adc
      logic [2:0]        lo_code;
      logic [2:0]        hi_code;
      logic [4:0]        want;
      logic [2:0]        code;
      logic [7:0]        ana_db;
      logic signed [7:0] g_left;

      always_comb begin
         g_left  = $signed(chan_gain[2*a]);
         lo_code = (ana_min == 3'h0) ? RLC_ANA_0DB : ana_min;
         hi_code = (ana_max > RLC_ANA_TOP || ana_max == 3'h0) ? RLC_ANA_TOP
                                                              : ana_max;
         if (g_left <= 8'sd0) begin
            want = 5'(RLC_ANA_0DB);
         end else begin
            want = 5'(g_left[6:0] / 7'd6) + 5'd1;
         end
         if (want < {2'b00, lo_code}) begin
            code = lo_code;
         end else if (want > {2'b00, hi_code}) begin
            code = hi_code;
         end else begin
            code = want[2:0];
         end
         if (code > hi_code) begin
            code = hi_code;
         end
         if (!hyb_sel[2*a]) begin
            code = RLC_ANA_0DB;
         end
         ana_db = {2'b00, code - 3'h1, 3'b000} - {4'h0, code - 3'h1, 1'b0} * 8'd1;
      end

      // Registered analog code and digital remainders
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            ana_gain_ff[a]     <= RLC_ANA_0DB;
            dig_gain_ff[2*a]   <= 8'h00;
            dig_gain_ff[2*a+1] <= 8'h00;
         end else begin
            ana_gain_ff[a]     <= code;
            dig_gain_ff[2*a]   <= chan_gain[2*a] - ana_db;
            dig_gain_ff[2*a+1] <= chan_gain[2*a+1] - ana_db;
         end
      end
   end

   // Output drivers, all from flip-flops
   assign prdata   = prdata_ff;
   assign pready   = pready_ff;
   assign pslverr  = pslverr_ff;
   assign dig_gain = dig_gain_ff;
   assign ana_gain = ana_gain_ff;

endmodule
`default_nettype wire

// ===== design/rlc_pkg.sv
// Package for the record level control block: register indices, field
// positions, reset values, write masks and the sample-period rate tables.
// Assumes a 32-bit APB slave where each register index maps to byte address 4*index.
package rlc_pkg;

   // Number of configuration registers and their indices
   localparam int         RLC_NCFG              = 9;
   localparam logic [7:0] RLC_IDX_ENABLE_HYBRID = 8'h30;
   localparam logic [7:0] RLC_IDX_RATES         = 8'h31;
   localparam logic [7:0] RLC_IDX_HOLD_TIME     = 8'h32;
   localparam logic [7:0] RLC_IDX_NOISE_FLOOR   = 8'h33;
   localparam logic [7:0] RLC_IDX_TARGET_LOW    = 8'h34;
   localparam logic [7:0] RLC_IDX_TARGET_HIGH   = 8'h35;
   localparam logic [7:0] RLC_IDX_GAIN_BOUNDS   = 8'h36;
   localparam logic [7:0] RLC_IDX_ANALOG_BOUNDS = 8'h37;
   localparam logic [7:0] RLC_IDX_CLIP_GUARD    = 8'h38;
   // Read-only gain readback (one per channel) and hold status
   localparam logic [7:0] RLC_IDX_GAIN_FIRST    = 8'h39;
   localparam logic [7:0] RLC_IDX_STATUS        = 8'h3D;

   // Reset values, listed from index 0x38 down to 0x30
   localparam logic [8:0][7:0] RLC_RST = {8'h00, 8'h71, 8'hFF, 8'h00, 8'h3F,
                                          8'h3F, 8'h00, 8'h00, 8'h00};
   // Writable bits; everything else reads as zero
   localparam logic [8:0][7:0] RLC_MASK = {8'h83, 8'h77, 8'hFF, 8'h3F, 8'h3F,
                                           8'h3F, 8'h0F, 8'hFF, 8'h5F};

   // Field positions
   localparam int RLC_EN_LSB        = 0;
   localparam int RLC_HYB_LSB       = 4;
   localparam int RLC_ATK_LSB       = 0;
   localparam int RLC_REL_LSB       = 4;
   localparam int RLC_HOLD_LSB      = 0;
   localparam int RLC_LVL_LSB       = 0;
   localparam int RLC_ATTN_LSB      = 0;
   localparam int RLC_GMAX_LSB      = 4;
   localparam int RLC_AMIN_LSB      = 0;
   localparam int RLC_AMAX_LSB      = 4;
   localparam int RLC_CLIP_EN_BIT   = 7;
   localparam int RLC_CLIP_STEP_LSB = 0;

   // Sample periods per dB of gain rise, by release code
   localparam logic [15:0][14:0] RLC_REL_TBL = {
      15'd29348, 15'd29348, 15'd29348, 15'd29348, 15'd29348, 15'd29348,
      15'd14674, 15'd7337, 15'd3668, 15'd1834, 15'd917, 15'd459,
      15'd229, 15'd115, 15'd57, 15'd29};
   // Sample periods per dB of gain fall, by attack code
   localparam logic [15:0][14:0] RLC_ATK_TBL = {
      15'd30024, 15'd30024, 15'd30024, 15'd30024, 15'd15012, 15'd7506,
      15'd3753, 15'd1876, 15'd938, 15'd469, 15'd235, 15'd117,
      15'd59, 15'd29, 15'd15, 15'd7};
   // Fast clip steps 0.034, 0.068, 0.136 dB per sample as periods per dB
   localparam logic [3:0][14:0] RLC_CLIP_TBL = {15'd7, 15'd7, 15'd15, 15'd29};
   // Hold time for code zero; each code doubles it
   localparam logic [20:0] RLC_HOLD_BASE = 21'd62;

   // Analog gain codes: 0 dB and the highest legal maximum (24 dB)
   localparam logic [2:0] RLC_ANA_0DB = 3'h1;
   localparam logic [2:0] RLC_ANA_TOP = 3'h5;

   // Gain-control phase of one channel
   typedef enum logic [2:0] {
      RLC_OFF,
      RLC_STEADY,
      RLC_ATTACK,
      RLC_HOLD,
      RLC_RELEASE
   } rlc_phase_e;

endpackage

// ===== verif/rlc_level_ctl_checker.sv
// Checker for the record level control block: APB answer timing and
// gain output relations, seen from the top module's ports only.
// Assumes one clock domain, reset nrst asynchronous and active low.
`timescale 1ns/10ps
`default_nettype none
module rlc_level_ctl_checker (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sample_tick,
   input wire logic [31:0] level_att,
   input wire logic [31:0] dig_gain,
   input wire logic [5:0]  ana_gain
);
   logic       wr_done;
   logic [9:0] idx;
   // Completed write and word index of the current access
   assign wr_done = psel && penable && pready && pwrite;
   assign idx     = paddr[11:2];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // Setup cycle, then an answer that stands one cycle only
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      psel && penable && pready ##1 !pready;
   endsequence
   // A real step on channel 0, not the forced clear of a disabled channel
   sequence s_step0;
      $changed(dig_gain[7:0]) && (dig_gain[7:0] != 8'h00);
   endsequence

   AST_APB_ANSWER: assert property (s_setup |=> s_answer)
      else $error("APB access not answered after one cycle");
   AST_UNMAPPED_ERR: assert property (psel && penable && pready |->
      pslverr == (idx < 10'h030 || idx > 10'h03D))
      else $error("pslverr does not match the address decode");
   AST_READ_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("read data has bits set above the register width");
   AST_RESET_GAIN: assert property (!$past(nrst) |-> dig_gain == 32'h0000_0000
      && ana_gain == 6'h09)
      else $error("gain outputs not idle after reset");
   // The digital gain moves only as a result of a sample or a register write
   AST_GAIN_CAUSE: assert property ($changed(dig_gain) |-> $past(sample_tick) ||
      $past(sample_tick, 2) || $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
      else $error("digital gain changed without a sample or a write");
   AST_UNIT_STEP: assert property ($changed(dig_gain[7:0]) |-> dig_gain[7:0] == 8'h00 ||
      8'(dig_gain[7:0] - $past(dig_gain[7:0])) inside {8'h01, 8'hFF})
      else $error("channel 0 gain moved by more than one step");
   // Fastest rate is seven samples per step, so six quiet cycles at least
   AST_STEP_SPACING: assert property (s_step0 |=> $stable(dig_gain[7:0]) [*6])
      else $error("channel 0 gain stepped too soon after the last step");
   AST_GAIN_RANGE: assert property ($signed(dig_gain[7:0]) >= -8'sd90 &&
      $signed(dig_gain[7:0]) <= 8'sd90)
      else $error("channel 0 gain outside the widest limit");
   AST_ANA_LEGAL: assert property (ana_gain[2:0] != 3'h0 && ana_gain[5:3] != 3'h0)
      else $error("analog gain code is the reserved value");
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Testbench for the record level control block: register checks over APB
// and gain scenarios driven through the record path ports.
// Assumes the package, the design and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import rlc_pkg::*;
   logic        clk, nrst, psel, penable, pwrite, pready, pslverr, sample_tick, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, level_att, dig_gain, rd;
   logic [3:0]  pstrb;
   logic [5:0]  ana_gain;
   int          err_count, check_count;
   // Reset values and writable bits, index order from 0x30
   localparam logic [7:0] RST_V [9] = '{8'h00, 8'h00, 8'h00, 8'h3F, 8'h3F, 8'h00,
                                        8'hFF, 8'h71, 8'h00};
   localparam logic [7:0] MSK_V [9] = '{8'h5F, 8'hFF, 8'h0F, 8'h3F, 8'h3F, 8'h3F,
                                        8'hFF, 8'h77, 8'h83};

   rlc_level_ctl dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
      .level_att(level_att), .dig_gain(dig_gain), .ana_gain(ana_gain));

   // 20 MHz clock
   always #25 clk = ~clk;

   task automatic complete_run;
      if (err_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the wait for pready is bounded by the watchdog only
   task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d,
                      input logic s);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {2'b00, ix, 2'b00};
      pwdata  <= {24'h00_0000, d};
      pstrb   <= {4{s}};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      apb(1'b1, ix, d, 1'b1);
   endtask
   task automatic rchk(input logic [7:0] ix, input logic [7:0] e);
      apb(1'b0, ix, 8'h00, 1'b1);
      chk(rd, {24'h00_0000, e});
   endtask
   // Sample strobes one cycle wide, one every two cycles
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clk);
         sample_tick <= 1'b1;
         @(posedge clk);
         sample_tick <= 1'b0;
      end
   endtask

   // Main sequence
   initial begin
      clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'h0; sample_tick = 1'b0;
      level_att = 32'h0000_0000; err_count = 0; check_count = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         rchk(RLC_IDX_ENABLE_HYBRID + 8'(i), RST_V[i]);
      end
      // Write all ones then all zeros; reserved bits must stay clear
      for (int i = 0; i < 9; i++) begin
         wr(RLC_IDX_ENABLE_HYBRID + 8'(i), 8'hFF);
         rchk(RLC_IDX_ENABLE_HYBRID + 8'(i), MSK_V[i]);
         wr(RLC_IDX_ENABLE_HYBRID + 8'(i), 8'h00);
         rchk(RLC_IDX_ENABLE_HYBRID + 8'(i), 8'h00);
      end
      apb(1'b1, RLC_IDX_RATES, 8'hFF, 1'b0);
      rchk(RLC_IDX_RATES, 8'h00);
      apb(1'b0, 8'h20, 8'h00, 1'b1);
      chk({31'h0, er}, 32'h0000_0001);
      apb(1'b1, RLC_IDX_GAIN_FIRST, 8'hFF, 1'b1);
      chk({31'h0, er}, 32'h0000_0000);
      // Limits of +-6 dB, targets far apart, attack 29 and release 29 per dB
      wr(RLC_IDX_GAIN_BOUNDS, 8'h11);
      wr(RLC_IDX_TARGET_HIGH, 8'h0A);
      wr(RLC_IDX_TARGET_LOW, 8'h10);
      wr(RLC_IDX_RATES, 8'h02);
      wr(RLC_IDX_NOISE_FLOOR, 8'h3F);
      level_att <= 32'h00F0_0000;
      wr(RLC_IDX_ENABLE_HYBRID, 8'h07);
      ticks(35);
      rchk(RLC_IDX_GAIN_FIRST, 8'hFF);
      rchk(RLC_IDX_GAIN_FIRST + 8'h01, 8'hFF);
      rchk(RLC_IDX_GAIN_FIRST + 8'h02, 8'h00);
      rchk(RLC_IDX_GAIN_FIRST + 8'h03, 8'h00);
      chk({26'h0, ana_gain}, 32'h0000_0009);
      // Clip guard at the fastest step reaches the attenuation limit
      wr(RLC_IDX_CLIP_GUARD, 8'h82);
      ticks(50);
      rchk(RLC_IDX_GAIN_FIRST, 8'hFA);
      // Low input above the noise floor: hold first, then release up to the gain limit
      level_att <= 32'h00F0_6464;
      ticks(50);
      rchk(RLC_IDX_GAIN_FIRST, 8'hFA);
      rchk(RLC_IDX_STATUS, 8'h03);
      ticks(60);
      rchk(RLC_IDX_GAIN_FIRST, 8'hFB);
      ticks(450);
      rchk(RLC_IDX_GAIN_FIRST, 8'h06);
      rchk(RLC_IDX_GAIN_FIRST + 8'h01, 8'h06);
      // Hybrid on the second ADC only, analog bounds 6 dB to 12 dB
      wr(RLC_IDX_ANALOG_BOUNDS, 8'h32);
      wr(RLC_IDX_ENABLE_HYBRID, 8'h47);
      ticks(2);
      chk({31'h0, ana_gain[5:3] >= 3'h2 && ana_gain[5:3] <= 3'h3}, 32'h0000_0001);
      chk({29'h0, ana_gain[2:0]}, 32'h0000_0001);
      wr(RLC_IDX_ENABLE_HYBRID, 8'h00);
      repeat (4) @(posedge clk);
      chk(dig_gain, 32'h0000_0000);
      complete_run;
   end

   // Watchdog well beyond the expected run of about 1500 cycles
   initial begin
      repeat (6000) @(posedge clk);
      err_count++;
      complete_run;
   end
endmodule

bind rlc_level_ctl rlc_level_ctl_checker chk_i (.clk(clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
   .level_att(level_att), .dig_gain(dig_gain), .ana_gain(ana_gain));
`default_nettype wire
